// *** hdl/led_link_map.svh ***
// Function
// (R1) Transition clear: linking with host request flips state
// (R2) Transition set, invert on: hold, touch toggles
// (R3) Transition set, invert off: hold, touch no change
// (R4) Software sets invert bit for breathe or pulse
// (R5) Transition bits at 0x77 and 0x78 layout
// (R6) Mirror bit references duty to 100 percent
// (R7) Polarity write updates mirror unless frozen
// (R8) Mirror bits at 0x79 and 0x7a layout
// (R9) Linked channel driven by its sensor touches
// (R10) Input-configured channel ignores its link bit
// (R11) Up/down link: up events actuate channel 10
// (R12) Up/down link: down events actuate channel 9
// (R13) Channels 9 and 10 never active together
// (R14) Unlinked channel follows host output request
// (R15) Linked channel actuates on touch, auto-enabled
// (R16) Link register: bits 0-6 sensors, bit 7 up/down
// (R17) Linked touch equals host request of one
// (R18) Source switch immediate, pulses finish first
// (R19) Unused bits ignore writes, read zero
`ifndef LED_LINK_MAP_SVH
`define LED_LINK_MAP_SVH
// ****************************************
// Register indices; the byte address is four times the index
// ****************************************
`define TRAN_A_IDX 8'h77
`define TRAN_B_IDX 8'h78
`define MIR_A_IDX 8'h79
`define MIR_B_IDX 8'h7a
`define LINK_IDX 8'h80
`define CFG_IDX 8'h84
`define POL_A_IDX 8'h85
`define POL_B_IDX 8'h86
`define STAT_A_IDX 8'h87
`define STAT_B_IDX 8'h88
// ****************************************
// Writable masks and reset values
// ****************************************
`define TRAN_A_MASK 8'h7f
`define TRAN_B_MASK 8'h03
`define MIR_A_MASK 8'hff
`define MIR_B_MASK 8'h07
`define LINK_MASK 8'hff
`define CFG_MASK 8'h03
`define POL_B_MASK 8'h07
`define STAT_B_MASK 8'h07
`define REG_RESET 8'h00
// ****************************************
// Field positions
// ****************************************
`define UPDOWN_BIT 7
`define CFG_INV_BIT 0
`define CFG_FREEZE_BIT 1
`define CH9 8
`define CH10 9
`endif

// *** hdl/led_link_pkg.sv ***
// ****************************************
// Types for the linking block
// ****************************************
package led_link_pkg;
  // Behaviour field encodings
  typedef enum logic [1:0] {
    BEH_DIRECT = 2'h0,
    BEH_PULSE1 = 2'h1,
    BEH_PULSE2 = 2'h2,
    BEH_BREATHE = 2'h3
  } behaviour_t;
  // Sensor group events
  typedef struct packed {
    logic up_evt;
    logic down_evt;
  } group_evt_t;
  // AHB-Lite request bundle
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } ahb_req_t;
  // Bus phase states, one-hot
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_DATA = 2'b10
  } phase_t;
endpackage : led_link_pkg

// *** hdl/led_sensor_link_control.sv ***
`include "led_link_map.svh"
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Sensor to output link control
// ****************************************
module led_sensor_link_control #(
  parameter int NCH = 11
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire led_link_pkg::ahb_req_t ahb_req_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [6:0] touch_i,
  input wire led_link_pkg::group_evt_t group_evt_i,
  input wire logic group_release_i,
  input wire logic [10:0] host_output_request_i,
  input wire logic [21:0] behaviour_select_field_i,
  input wire logic [10:0] pin_is_input_i,
  input wire logic [10:0] pulse_busy_i,
  output logic [10:0] actuate_o,
  output logic [10:0] output_enable_o,
  output logic [10:0] duty_reference_flip_o,
  output logic [10:0] output_polarity_bit_o
);
  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] link_transition_ctrl_a; // Transition select, ch1-7
  logic [7:0] link_transition_ctrl_b; // Transition select, ch9-10
  logic [7:0] duty_mirror_ctrl_a; // Mirror, ch1-8
  logic [7:0] duty_mirror_ctrl_b; // Mirror, ch9-11
  logic [7:0] sensor_output_linking; // Link bits
  logic [7:0] link_cfg; // Invert and freeze bits
  logic [7:0] polarity_a; // Polarity ch1-8
  logic [7:0] polarity_b; // Polarity ch9-11
  led_link_pkg::phase_t phase; // Bus phase
  logic [7:0] wr_idx; // Latched write index
  logic [10:0] linked_d; // Link state last cycle
  logic [10:0] flip; // Per-channel toggle state
  logic [10:0] linked; // Effective link per channel
  logic [10:0] link_rise; // Channel just became linked
  logic [10:0] touch_ch; // Touch per channel
  logic [10:0] touch_d; // Touch last cycle
  logic [10:0] cmd; // Source command per channel
  logic [10:0] held; // Held actuation during pulses
  logic [10:0] hold_now; // Host state held, linking cycle included
  logic [10:0] next_act; // Next actuation
  logic [1:0] grp; // Latched group state, ch9 bit0
  logic [10:0] tran_sel; // Transition select per channel
  logic [10:0] pol_w; // Polarity write strobes
  logic [10:0] pol_new; // Written polarity values
  logic inv_global; // inverted_link_change_global
  logic freeze_auto_flip; // Blocks mirror auto update
  logic wr_en; // Data-phase write strobe
  // Word index from a byte address
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction : word_idx
  // Pack one register byte with reserved bits forced low
  function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
    masked = d & m;
  endfunction : masked

  assign inv_global = link_cfg[`CFG_INV_BIT];
  assign freeze_auto_flip = link_cfg[`CFG_FREEZE_BIT];
  assign hreadyout_o = 1'b1; // Zero wait states
  assign hresp_o = 1'b0; // Always OKAY
  assign wr_en = (phase == led_link_pkg::PH_DATA);

  // ****************************************
  // AHB address phase capture
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      phase <= led_link_pkg::PH_IDLE;
      wr_idx <= 8'h00;
    end
    else if (ahb_req_i.hready)
    begin
      // Only selected writes open a write data phase
      if (ahb_req_i.hsel && ahb_req_i.htrans[1] && ahb_req_i.hwrite)
      begin
        phase <= led_link_pkg::PH_DATA;
        wr_idx <= word_idx(ahb_req_i.haddr);
      end
      else
      begin
        phase <= led_link_pkg::PH_IDLE;
      end
    end
  end

  // ****************************************
  // Read data, registered off the address phase
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hrdata_o <= 32'h00000000;
    end
    else if (ahb_req_i.hready && ahb_req_i.hsel && ahb_req_i.htrans[1] && !ahb_req_i.hwrite)
    begin
      // Unmapped words read as zero
      case (word_idx(ahb_req_i.haddr))
        `TRAN_A_IDX: hrdata_o <= {24'h000000, link_transition_ctrl_a}; // [R5] [R19]
        `TRAN_B_IDX: hrdata_o <= {24'h000000, link_transition_ctrl_b}; // [R5] [R19]
        `MIR_A_IDX: hrdata_o <= {24'h000000, duty_mirror_ctrl_a}; // [R8]
        `MIR_B_IDX: hrdata_o <= {24'h000000, duty_mirror_ctrl_b}; // [R8] [R19]
        `LINK_IDX: hrdata_o <= {24'h000000, sensor_output_linking}; // [R16]
        `CFG_IDX: hrdata_o <= {24'h000000, link_cfg};
        `POL_A_IDX: hrdata_o <= {24'h000000, polarity_a};
        `POL_B_IDX: hrdata_o <= {24'h000000, polarity_b};
        `STAT_A_IDX: hrdata_o <= {24'h000000, actuate_o[7:0]};
        `STAT_B_IDX: hrdata_o <= {24'h000000, masked({5'h00, actuate_o[10:8]}, `STAT_B_MASK)};
        default: hrdata_o <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // Plain control registers
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      link_transition_ctrl_a <= `REG_RESET;
      link_transition_ctrl_b <= `REG_RESET;
      sensor_output_linking <= `REG_RESET;
      link_cfg <= `REG_RESET;
      polarity_a <= `REG_RESET;
      polarity_b <= `REG_RESET;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        `TRAN_A_IDX: link_transition_ctrl_a <= masked(hwdata_i[7:0], `TRAN_A_MASK); // [R5] [R19]
        `TRAN_B_IDX: link_transition_ctrl_b <= masked(hwdata_i[7:0], `TRAN_B_MASK); // [R5] [R19]
        `LINK_IDX: sensor_output_linking <= masked(hwdata_i[7:0], `LINK_MASK); // [R16]
        `CFG_IDX: link_cfg <= masked(hwdata_i[7:0], `CFG_MASK);
        `POL_A_IDX: polarity_a <= hwdata_i[7:0];
        `POL_B_IDX: polarity_b <= masked(hwdata_i[7:0], `POL_B_MASK);
        default: ;
      endcase
    end
  end

  // Polarity write strobes, only changed bits count
  always_comb
  begin
    pol_w = 11'h000;
    pol_new = {polarity_b[2:0], polarity_a};
    if (wr_en && wr_idx == `POL_A_IDX)
    begin
      pol_new[7:0] = hwdata_i[7:0];
      pol_w[7:0] = hwdata_i[7:0] ^ polarity_a;
    end
    else if (wr_en && wr_idx == `POL_B_IDX)
    begin
      pol_new[10:8] = hwdata_i[2:0];
      pol_w[10:8] = hwdata_i[2:0] ^ polarity_b[2:0];
    end
  end

  // ****************************************
  // Mirror registers with polarity tracking
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      duty_mirror_ctrl_a <= `REG_RESET;
      duty_mirror_ctrl_b <= `REG_RESET;
    end
    else if (wr_en && wr_idx == `MIR_A_IDX)
    begin
      duty_mirror_ctrl_a <= masked(hwdata_i[7:0], `MIR_A_MASK); // [R8]
    end
    else if (wr_en && wr_idx == `MIR_B_IDX)
    begin
      duty_mirror_ctrl_b <= masked(hwdata_i[7:0], `MIR_B_MASK); // [R8] [R19]
    end
    else if (!freeze_auto_flip)
    begin
      // Changed polarity copies into mirror [R7]
      for (int i = 0; i < 8; i++)
        if (pol_w[i])
          duty_mirror_ctrl_a[i] <= pol_new[i]; // [R7]
      for (int i = 0; i < 3; i++)
        if (pol_w[8+i])
          duty_mirror_ctrl_b[i] <= pol_new[8+i]; // [R7]
    end
  end

  // Mirror passes out to the duty engine [R6]
  assign duty_reference_flip_o = {duty_mirror_ctrl_b[2:0], duty_mirror_ctrl_a}; // [R6]
  assign output_polarity_bit_o = {polarity_b[2:0], polarity_a};

  // ****************************************
  // Per-channel link decode
  // ****************************************
  always_comb
  begin
    linked = 11'h000;
    touch_ch = 11'h000;
    tran_sel = 11'h000;
    linked[6:0] = sensor_output_linking[6:0]; // [R16]
    linked[`CH9] = sensor_output_linking[`UPDOWN_BIT]; // [R12]
    linked[`CH10] = sensor_output_linking[`UPDOWN_BIT]; // [R11]
    linked = linked & ~pin_is_input_i; // [R10]
    touch_ch[6:0] = touch_i;
    touch_ch[`CH9] = grp[0];
    touch_ch[`CH10] = grp[1];
    tran_sel[6:0] = link_transition_ctrl_a[6:0]; // [R5]
    tran_sel[`CH9] = link_transition_ctrl_b[0]; // [R5]
    tran_sel[`CH10] = link_transition_ctrl_b[1]; // [R5]
  end
  assign link_rise = linked & ~linked_d;

  // ****************************************
  // Group events: last one wins, release clears
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      grp <= 2'b00;
    end
    else if (group_evt_i.up_evt)
    begin
      grp <= 2'b10; // Up forces channel 9 off [R11] [R13]
    end
    else if (group_evt_i.down_evt)
    begin
      grp <= 2'b01; // Down forces channel 10 off [R12] [R13]
    end
    else if (group_release_i)
    begin
      grp <= 2'b00;
    end
  end

  // ****************************************
  // Transition toggle state per channel
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flip <= 11'h000;
      linked_d <= 11'h000;
      touch_d <= 11'h000;
    end
    else
    begin
      linked_d <= linked;
      touch_d <= touch_ch;
      for (int i = 0; i < NCH; i++)
      begin
        if (!linked[i])
          flip[i] <= 1'b0;
        else if (link_rise[i] && tran_sel[i] && host_output_request_i[i] && !touch_ch[i])
          flip[i] <= 1'b1; // Keep the host state across linking [R2] [R3]
        else if (flip[i] && !inv_global && touch_ch[i] && !touch_d[i])
          flip[i] <= 1'b0; // No change seen on this touch [R3]
      end
    end
  end

  // ****************************************
  // Hold of the host state across linking
  // ****************************************
  // Covers the linking cycle too, so the output never dips for one cycle
  always_comb
  begin
    hold_now = 11'h000;
    for (int i = 0; i < NCH; i++)
    begin
      hold_now[i] = flip[i] || (link_rise[i] && tran_sel[i] && host_output_request_i[i]
        && !touch_ch[i]); // [R2] [R3]
    end
  end

  // Command source: touch mimics host bit [R17]
  always_comb
  begin
    cmd = 11'h000;
    for (int i = 0; i < NCH; i++)
    begin
      if (!linked[i])
        cmd[i] = host_output_request_i[i]; // [R14]
      else if (hold_now[i] && !inv_global)
        cmd[i] = 1'b1; // Held state survives the first touch [R3]
      else
        cmd[i] = touch_ch[i] ^ hold_now[i]; // [R9] [R15] [R17] [R1] [R2]
    end
    // Clear transition: plain touch, so linking drops host state [R1]
  end

  // ****************************************
  // Actuation with pulse completion
  // ****************************************
  always_comb
  begin
    led_link_pkg::behaviour_t b; // Behaviour of the channel in hand
    b = led_link_pkg::BEH_DIRECT;
    next_act = 11'h000;
    for (int i = 0; i < NCH; i++)
    begin
      b = led_link_pkg::behaviour_t'(behaviour_select_field_i[2*i +: 2]);
      if ((b == led_link_pkg::BEH_PULSE1 || b == led_link_pkg::BEH_PULSE2) && pulse_busy_i[i])
        next_act[i] = held[i]; // Pulse finishes before source change [R18]
      else
        next_act[i] = cmd[i]; // Direct and breathe follow at once [R18]
    end
    if (next_act[`CH9] && next_act[`CH10])
      next_act[`CH9] = 1'b0; // Exclusive pair [R13]
  end

  // Registered actuation; input pins never actuate
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      held <= 11'h000;
      actuate_o <= 11'h000;
      output_enable_o <= 11'h000;
    end
    else
    begin
      held <= next_act;
      actuate_o <= next_act & ~pin_is_input_i;
      output_enable_o <= linked; // Linked outputs auto-enabled [R15]
    end
  end
endmodule : led_sensor_link_control
`default_nettype wire

// *** verification/led_link_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Link control checker
// ****
module led_link_props (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire led_link_pkg::ahb_req_t ahb_req_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire led_link_pkg::group_evt_t group_evt_i,
  input wire logic [10:0] host_output_request_i,
  input wire logic [21:0] behaviour_select_field_i,
  input wire logic [10:0] pin_is_input_i,
  input wire logic [10:0] actuate_o,
  input wire logic [10:0] output_enable_o,
  input wire logic [10:0] duty_reference_flip_o,
  input wire logic [10:0] output_polarity_bit_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Write taken in an address phase
  logic wr;
  assign wr = ahb_req_i.hsel && ahb_req_i.htrans[1] && ahb_req_i.hwrite && ahb_req_i.hready;
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus stalled or erred");
  a_upper_zero: assert property (hrdata_o[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  a_group_excl: assert property (!(actuate_o[8] && actuate_o[9]))
    else $error("both group channels on");
  a_input_unlinked: assert property ((output_enable_o & $past(pin_is_input_i)) == 11'h0)
    else $error("input pin enabled");
  a_up_actuates: assert property (group_evt_i.up_evt && output_enable_o[9]
    && behaviour_select_field_i[19:18] == 2'h0 |=> ##1 actuate_o[9] && !actuate_o[8])
    else $error("up event missed");
  a_down_actuates: assert property (group_evt_i.down_evt && !group_evt_i.up_evt
    && output_enable_o[8] && behaviour_select_field_i[17:16] == 2'h0
    |=> ##1 actuate_o[8] && !actuate_o[9])
    else $error("down event missed");
  a_host_follow: assert property (!output_enable_o[0] && !pin_is_input_i[0]
    && behaviour_select_field_i[1:0] == 2'h0 ##1 !output_enable_o[0]
    |-> actuate_o[0] == $past(host_output_request_i[0]))
    else $error("unlinked channel ignores host");
  // Mirror follows a polarity write at the same edge as polarity; a third cycle is also allowed
  a_flip_cause: assert property ($changed(duty_reference_flip_o)
    |-> $past(wr, 2) || $past(wr, 3))
    else $error("mirror changed without a write");
  a_pol_cause: assert property ($changed(output_polarity_bit_o) |-> $past(wr, 2))
    else $error("polarity changed without a write");
  c_group: cover property (group_evt_i.up_evt ##2 actuate_o[9]);
  c_linked: cover property (output_enable_o[0] && actuate_o[0]);
  c_flip: cover property ($changed(duty_reference_flip_o));
endmodule : led_link_props
bind led_sensor_link_control led_link_props led_link_props_i (.*);
`default_nettype wire

// *** verification/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// Host bits and touch detection
// ****
module host_model (
  input wire logic ref_clk_i,
  output logic [6:0] touch_o,
  output led_link_pkg::group_evt_t evt_o,
  output logic release_o,
  output logic [10:0] host_o
);
  // Quiet sensors from time zero
  initial
  begin
    touch_o = 7'h00;
    evt_o = 2'h0;
    release_o = 1'b0;
    host_o = 11'h000;
  end
  // Touch level, changed just after an edge
  task automatic touch(input int ch, input logic v);
    @(posedge ref_clk_i);
    touch_o[ch] <= v;
  endtask : touch
  // Host request bit, held as a level
  task automatic host(input int ch, input logic v);
    @(posedge ref_clk_i);
    host_o[ch] <= v;
  endtask : host
  // Group event lasts one cycle only
  task automatic evt(input logic up);
    @(posedge ref_clk_i);
    evt_o <= up ? 2'h2 : 2'h1;
    @(posedge ref_clk_i);
    evt_o <= 2'h0;
  endtask : evt
  // Group release lasts one cycle only
  task automatic rel();
    @(posedge ref_clk_i);
    release_o <= 1'b1;
    @(posedge ref_clk_i);
    release_o <= 1'b0;
  endtask : rel
endmodule : host_model
`default_nettype wire

// *** verification/tb_led_sensor_link_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "led_link_map.svh"
// ****
// Link control bench
// ****
module tb_led_sensor_link_control;
  logic ref_clk_i, arst_n_i, rdy, grel;
  led_link_pkg::ahb_req_t req;
  led_link_pkg::group_evt_t gev;
  logic [31:0] wdata, rdata, q;
  logic [6:0] touch;
  logic [10:0] host, pin_in, act, oen, flip, pol, busy;
  logic [21:0] beh;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Bus hready is the slave's own ready
  led_sensor_link_control led_sensor_link_control_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ahb_req_i({req[39:1], rdy}),
    .hwdata_i(wdata), .hrdata_o(rdata), .hreadyout_o(rdy), .hresp_o(),
    .touch_i(touch), .group_evt_i(gev), .group_release_i(grel),
    .host_output_request_i(host), .behaviour_select_field_i(beh),
    .pin_is_input_i(pin_in), .pulse_busy_i(busy), .actuate_o(act),
    .output_enable_o(oen), .duty_reference_flip_o(flip), .output_polarity_bit_o(pol));
  host_model host_model_i (.ref_clk_i(ref_clk_i), .touch_o(touch), .evt_o(gev),
    .release_o(grel), .host_o(host));
  // Free running 125 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One word transfer; read data taken at the closing edge
  task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
    @(posedge ref_clk_i);
    req <= '{1'b1, {22'h0, ix, 2'b00}, 2'h2, w, 3'h2, 1'b1};
    do @(posedge ref_clk_i); while (rdy !== 1'b1);
    req.htrans <= 2'h0;
    wdata <= d;
    do @(posedge ref_clk_i); while (rdy !== 1'b1);
    q = rdata;
  endtask : bus
  // Let registered actuation settle, then look
  task automatic ca(input string n, input int ch, input logic e);
    repeat (3) @(posedge ref_clk_i);
    chk(n, {31'h0, e}, {31'h0, act[ch]});
  endtask : ca
  // Reset values and writable bits, unmapped place last
  task automatic t_regs();
    logic [7:0] ix [6] = '{`TRAN_A_IDX, `TRAN_B_IDX, `MIR_A_IDX, `MIR_B_IDX, `LINK_IDX, 8'h90};
    logic [7:0] mk [6] = '{8'h7f, 8'h03, 8'hff, 8'h07, 8'hff, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, ix[i], 32'h0);
      chk("reset", 32'h0, q);
      bus(1'b1, ix[i], 32'hffffffff);
      bus(1'b0, ix[i], 32'h0);
      chk("mask", {24'h0, mk[i]}, q);
      bus(1'b1, ix[i], 32'h0);
    end
  endtask : t_regs
  // Host source, then touch source, then an input pin
  task automatic t_link();
    host_model_i.host(0, 1'b1);
    ca("host_on", 0, 1'b1);
    host_model_i.host(0, 1'b0);
    host_model_i.touch(0, 1'b1);
    ca("unlinked_touch", 0, 1'b0);
    bus(1'b1, `LINK_IDX, 32'h3);
    pin_in <= 11'h002;
    ca("linked_touch", 0, 1'b1);
    chk("enable", 32'h001, {21'h0, oen});
    bus(1'b0, `STAT_A_IDX, 32'h0);
    chk("status", 32'h1, q);
    host_model_i.touch(0, 1'b0);
    ca("release", 0, 1'b0);
    bus(1'b1, `LINK_IDX, 32'h0);
    pin_in <= 11'h000;
  endtask : t_link
  // Host on, link, then touch on one channel
  task automatic tr(input int ch, input logic tb, input logic iv, input logic el, input logic et);
    bus(1'b1, `TRAN_A_IDX, {31'h0, tb} << ch);
    bus(1'b1, `CFG_IDX, {31'h0, iv});
    host_model_i.host(ch, 1'b1);
    ca("pre_link", ch, 1'b1);
    bus(1'b1, `LINK_IDX, 32'h1 << ch);
    ca("on_link", ch, el);
    host_model_i.touch(ch, 1'b1);
    ca("on_touch", ch, et);
    host_model_i.touch(ch, 1'b0);
    host_model_i.host(ch, 1'b0);
    bus(1'b1, `LINK_IDX, 32'h0);
    bus(1'b1, `TRAN_A_IDX, 32'h0);
  endtask : tr
  // Up and down events on the grouped pair
  task automatic t_group();
    bus(1'b1, `LINK_IDX, 32'h80);
    host_model_i.evt(1'b1);
    ca("up", 9, 1'b1);
    host_model_i.evt(1'b0);
    ca("down", 8, 1'b1);
    chk("pair", 32'h1, {30'h0, act[9:8]});
    host_model_i.rel();
    ca("group_release", 8, 1'b0);
    bus(1'b1, `LINK_IDX, 32'h0);
  endtask : t_group
  // Pulse on channel 5 finishes before a host request change
  task automatic t_pulse();
    beh <= 22'h000400;
    host_model_i.host(5, 1'b1);
    ca("pulse_start", 5, 1'b1);
    busy <= 11'h020;
    host_model_i.host(5, 1'b0);
    ca("pulse_held", 5, 1'b1);
    busy <= 11'h000;
    ca("pulse_done", 5, 1'b0);
    beh <= 22'h0;
  endtask : t_pulse
  // Polarity copy into mirror, then frozen
  task automatic t_mirror();
    bus(1'b1, `POL_A_IDX, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    chk("auto_flip", 32'h001, {21'h0, flip});
    bus(1'b1, `CFG_IDX, 32'h2);
    bus(1'b1, `POL_A_IDX, 32'h3);
    bus(1'b1, `MIR_B_IDX, 32'h5);
    repeat (2) @(posedge ref_clk_i);
    chk("frozen_flip", 32'h501, {21'h0, flip});
    chk("polarity", 32'h003, {21'h0, pol});
  endtask : t_mirror
  initial
  begin
    arst_n_i = 1'b0;
    req = '0;
    wdata = 32'h0;
    beh = 22'h0;
    pin_in = 11'h0;
    busy = 11'h0;
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_link();
    tr(2, 1'b0, 1'b0, 1'b0, 1'b1);
    // Invert kept on, as software needs for breathe use
    tr(3, 1'b1, 1'b1, 1'b1, 1'b0);
    tr(4, 1'b1, 1'b0, 1'b1, 1'b1);
    t_group();
    t_pulse();
    t_mirror();
    conclude();
  end
endmodule : tb_led_sensor_link_control
`default_nettype wire
